// ===== mmd_pkg.sv
// Purpose: Shared constants and carriers for the DSP memory map decoder
// Assumes: 16-bit address and data, 32-bit AXI4-Lite register bus
// Notes: Address windows are inclusive base/limit pairs
`default_nettype none
package mmd_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	// Register area and on-chip block windows in data space
	localparam logic [15:0] MMR_LIMIT = 16'h005F;
	localparam logic [15:0] BLK2_BASE = 16'h0060;
	localparam logic [15:0] BLK2_LIMIT = 16'h007F;
	localparam logic [15:0] BLK0D_BASE = 16'h0100;
	localparam logic [15:0] BLK0D_LIMIT = 16'h02FF;
	localparam logic [15:0] BLK1_BASE = 16'h0300;
	localparam logic [15:0] BLK1_LIMIT = 16'h04FF;
	localparam logic [15:0] SAD_BASE = 16'h0800;
	localparam logic [15:0] SAD_LIMIT = 16'h17FF;
	// Program space windows
	localparam logic [15:0] FLASH_LIMIT = 16'h7FFF;
	localparam logic [15:0] SAP_BASE = 16'h8000;
	localparam logic [15:0] SAP_LIMIT = 16'h8FFF;
	localparam logic [15:0] BLK0P_BASE = 16'hFE00;
	// Memory index widths
	localparam int BLK0_AW = 8;
	localparam int BLK2_AW = 5;
	localparam int SA_AW = 12;
	localparam int FL_AW = 15;
	// Global allocation: smallest mask that enables a region (32K words)
	localparam logic [7:0] GALLOC_MIN = 8'h80;
	// Register map, byte addresses
	localparam logic [7:0] REG_MODE_STAT = 8'h00;
	localparam logic [7:0] REG_GALLOC = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Status register field positions
	localparam int PM_MODE = 0;
	localparam int PM_BLK0_SEL = 1;
	localparam int PM_PROG_EN = 2;
	localparam int PM_DATA_EN = 3;
	localparam logic [3:0] MODE_STAT_RST = 4'hC;
	// Target of a decoded access
	typedef enum logic [3:0] {
		MMD_TGT_EXT, MMD_TGT_GLOBAL, MMD_TGT_MMR, MMD_TGT_BLK0, MMD_TGT_BLK1,
		MMD_TGT_BLK2, MMD_TGT_SRAM, MMD_TGT_FLASH
	} mmd_tgt_t;
	// Core access request
	typedef struct packed {
		logic valid;
		logic wr;
		logic [1:0] space; // 0 program, 1 data, 2 I/O
		logic [15:0] addr;
		logic [15:0] wdata;
	} mmd_req_t;
	localparam logic [1:0] SP_PROG = 2'h0;
	localparam logic [1:0] SP_DATA = 2'h1;
	localparam logic [1:0] SP_IO = 2'h2;
	// External bus request
	typedef struct packed {
		logic valid;
		logic wr;
		logic [1:0] space;
		logic global_sel;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mmd_ext_t;
endpackage
`default_nettype wire

// ===== mmd_ram.sv
// Purpose: Single-port word memory with registered read data
// Assumes: One access per cycle
// Notes: Used for every on-chip block
`timescale 1ns/100ps
`default_nettype none
module mmd_ram #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	// Clock
	input wire logic clk,
	// Access port
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	// Write then registered read
	always_ff @(posedge clk)
	begin
		if (en && we)
			mem[addr] <= wdata;
		if (en)
			rdata <= mem[addr];
	end
endmodule // mmd_ram
`default_nettype wire

// ===== mmd_decoder.sv
// Purpose: Steers core program, data and I/O accesses to on-chip blocks or external bus
// Assumes: One core access at a time; on-chip block read data returned one cycle after the request
// Notes: Mode pin synchronised and latched at reset release; registers over AXI4-Lite
// Summary of operation
// [RL1] Three separate 64K-word spaces, by bus
// [RL2] Top data region per allocation is global
// [RL3] Global accesses raise bus request first
// [RL4] Data 0 to 5Fh goes to registers
// [RL5] Dual RAM 544, single RAM 4K, flash 32K
// [RL6] Single RAM enables reset to one
// [RL7] Single RAM at data 800h, program 8000h
// [RL8] Mode pin high gives external program fetch
// [RL9] Mode pin latched into status bit 0
// [RL10] Status bits software readable and writable
// [RL11] Clearing bit 0 maps flash at zero
// [RL12] Bit clear: block zero at data 100h, 200h
// [RL13] Bit set: block zero at program FE00h, FF00h
// [RL14] Block one always at data 300h, 400h
// [RL15] Block two always at data 60h to 7Fh
// [RL16] Flash in lower program half when microcontroller
// [RL17] Unclaimed addresses go to external bus
`timescale 1ns/100ps
`default_nettype none
module mmd_decoder (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Mode pin
	input wire logic proc_mode_pin,
	// Core access
	input wire mmd_pkg::mmd_req_t core_req,
	output logic core_ready,
	output logic [15:0] core_rdata,
	output mmd_pkg::mmd_tgt_t core_tgt,
	// External bus
	output mmd_pkg::mmd_ext_t ext_req,
	input wire logic [15:0] ext_rdata,
	input wire logic ext_ready,
	output logic global_bus_request,
	input wire logic global_bus_grant,
	// Register access to core-side memory-mapped registers
	output logic mmr_sel,
	// AXI4-Lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	import mmd_pkg::*;

	logic pin_meta_reg, pin_sync_reg;
	logic rst_seen_reg;
	logic [3:0] proc_mode_status_reg;
	logic [7:0] global_alloc_reg;
	logic aw_held_reg, w_held_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	mmd_tgt_t tgt;
	mmd_tgt_t tgt_q_reg;
	logic [15:0] ram_addr;
	logic micro_proc, b0_space_select, sram_program_enable, sram_data_enable, is_global;
	logic [15:0] rd_blk0, rd_blk1, rd_blk2, rd_sa, rd_fl;
	logic acc, pend_reg;

	// Mapping controls taken from the status register
	assign micro_proc = proc_mode_status_reg[PM_MODE];
	assign b0_space_select = proc_mode_status_reg[PM_BLK0_SEL];
	assign sram_program_enable = proc_mode_status_reg[PM_PROG_EN];
	assign sram_data_enable = proc_mode_status_reg[PM_DATA_EN];

	// Two-stage synchroniser for the mode pin
	always_ff @(posedge clk)
	begin
		pin_meta_reg <= proc_mode_pin;
		pin_sync_reg <= pin_meta_reg;
	end

	// Global region: allocation bits mark top words as global; values below 80h disable
	// Region sizes are powers of two from 256 to 32K words [RL2]
	always_comb
	begin
		is_global = 1'b0;
		if (global_alloc_reg >= GALLOC_MIN)
			is_global = ((core_req.addr[15:8] & global_alloc_reg) == global_alloc_reg); // [RL2]
	end

	// Address decode per space [RL1]
	always_comb
	begin
		tgt = MMD_TGT_EXT; // [RL17]
		case (core_req.space)
			SP_DATA:
			begin
				if (core_req.addr <= MMR_LIMIT)
					tgt = MMD_TGT_MMR; // [RL4]
				else if (core_req.addr >= BLK2_BASE && core_req.addr <= BLK2_LIMIT)
					tgt = MMD_TGT_BLK2; // [RL15]
				else if (!b0_space_select && core_req.addr >= BLK0D_BASE
					&& core_req.addr <= BLK0D_LIMIT)
					tgt = MMD_TGT_BLK0; // [RL12]
				else if (core_req.addr >= BLK1_BASE && core_req.addr <= BLK1_LIMIT)
					tgt = MMD_TGT_BLK1; // [RL14]
				else if (sram_data_enable && core_req.addr >= SAD_BASE
					&& core_req.addr <= SAD_LIMIT)
					tgt = MMD_TGT_SRAM; // [RL6] [RL7]
				else if (is_global)
					tgt = MMD_TGT_GLOBAL; // [RL2]
			end
			SP_PROG:
			begin
				if (!micro_proc && core_req.addr <= FLASH_LIMIT)
					tgt = MMD_TGT_FLASH; // [RL11] [RL16]
				else if (sram_program_enable && core_req.addr >= SAP_BASE
					&& core_req.addr <= SAP_LIMIT)
					tgt = MMD_TGT_SRAM; // [RL6] [RL7]
				else if (b0_space_select && core_req.addr >= BLK0P_BASE)
					tgt = MMD_TGT_BLK0; // [RL13]
			end
			default:
				tgt = MMD_TGT_EXT; // [RL17]
		endcase
	end

	// Single RAM index shared by both spaces so the ranges reach the same words [RL7]
	assign ram_addr = (core_req.space == SP_DATA) ? (core_req.addr - SAD_BASE)
		: (core_req.addr - SAP_BASE);

	assign acc = core_req.valid && !pend_reg;

	// 256-word aliasing: only the low eight bits index blocks zero and one [RL12] [RL13] [RL14]
	mmd_ram #(.AW(BLK0_AW), .DW(DATA_W)) u_blk0 (
		.clk(clk), .en(acc && tgt == MMD_TGT_BLK0), .we(core_req.wr),
		.addr(core_req.addr[BLK0_AW-1:0]), .wdata(core_req.wdata), .rdata(rd_blk0));
	mmd_ram #(.AW(BLK0_AW), .DW(DATA_W)) u_blk1 (
		.clk(clk), .en(acc && tgt == MMD_TGT_BLK1), .we(core_req.wr),
		.addr(core_req.addr[BLK0_AW-1:0]), .wdata(core_req.wdata), .rdata(rd_blk1));
	mmd_ram #(.AW(BLK2_AW), .DW(DATA_W)) u_blk2 (
		.clk(clk), .en(acc && tgt == MMD_TGT_BLK2), .we(core_req.wr),
		.addr(core_req.addr[BLK2_AW-1:0]), .wdata(core_req.wdata), .rdata(rd_blk2));
	mmd_ram #(.AW(SA_AW), .DW(DATA_W)) u_sa (
		.clk(clk), .en(acc && tgt == MMD_TGT_SRAM), .we(core_req.wr),
		.addr(ram_addr[SA_AW-1:0]), .wdata(core_req.wdata), .rdata(rd_sa));
	// Flash array: writes stand for the core-run programming algorithm [RL5]
	mmd_ram #(.AW(FL_AW), .DW(DATA_W)) u_fl (
		.clk(clk), .en(acc && tgt == MMD_TGT_FLASH), .we(core_req.wr),
		.addr(core_req.addr[FL_AW-1:0]), .wdata(core_req.wdata), .rdata(rd_fl));

	// On-chip access takes one cycle; pending marks the read-data cycle
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pend_reg <= 1'b0;
			tgt_q_reg <= MMD_TGT_EXT;
		end
		else
		begin
			pend_reg <= acc && tgt != MMD_TGT_EXT && tgt != MMD_TGT_GLOBAL
				&& tgt != MMD_TGT_MMR;
			tgt_q_reg <= tgt;
		end
	end

	// Core answer: blocks after one cycle, register area at once, external when the bus is ready
	always_comb
	begin
		core_ready = 1'b0;
		if (pend_reg)
			core_ready = 1'b1;
		else if (core_req.valid && tgt == MMD_TGT_MMR)
			core_ready = 1'b1; // [RL4]
		else if (core_req.valid && tgt == MMD_TGT_EXT)
			core_ready = ext_ready; // [RL17]
		else if (core_req.valid && tgt == MMD_TGT_GLOBAL)
			core_ready = ext_ready && global_bus_grant; // [RL3]
	end

	// Read data return mux: a block word only in its data cycle, so a stale
	// registered target never steers block data onto an external or register read
	always_comb
	begin
		core_rdata = ext_rdata;
		if (pend_reg)
		begin
			case (tgt_q_reg)
				MMD_TGT_BLK0: core_rdata = rd_blk0;
				MMD_TGT_BLK1: core_rdata = rd_blk1;
				MMD_TGT_BLK2: core_rdata = rd_blk2;
				MMD_TGT_SRAM: core_rdata = rd_sa;
				MMD_TGT_FLASH: core_rdata = rd_fl;
				default: core_rdata = ext_rdata;
			endcase
		end
	end

	assign core_tgt = tgt;
	assign mmr_sel = core_req.valid && tgt == MMD_TGT_MMR; // [RL4]

	// External bus: global cycles wait for the grant after the request [RL3] [RL8]
	always_comb
	begin
		global_bus_request = core_req.valid && tgt == MMD_TGT_GLOBAL; // [RL3]
		ext_req.valid = core_req.valid && (tgt == MMD_TGT_EXT
			|| (tgt == MMD_TGT_GLOBAL && global_bus_grant)); // [RL3] [RL17]
		ext_req.wr = core_req.wr;
		ext_req.space = core_req.space;
		ext_req.global_sel = tgt == MMD_TGT_GLOBAL;
		ext_req.addr = core_req.addr;
		ext_req.wdata = core_req.wdata;
	end

	// Mode bit caught from the pin on the first cycle after reset release [RL9]
	always_ff @(posedge clk)
	begin
		if (srst)
			rst_seen_reg <= 1'b1;
		else
			rst_seen_reg <= 1'b0;
	end

	// AXI write address and data capture, either order
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end
		else if (s_bvalid && s_bready)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_wdata;
				wstrb_reg <= s_wstrb;
			end
		end
	end
	assign s_awready = !aw_held_reg;
	assign s_wready = !w_held_reg;
	assign s_bvalid = aw_held_reg && w_held_reg;
	assign s_bresp = (awaddr_reg == REG_MODE_STAT || awaddr_reg == REG_GALLOC
		|| awaddr_reg == REG_STAT) ? RESP_OKAY : RESP_SLVERR;

	// Status register: reset to mapping enables set, mode from pin [RL6] [RL9] [RL10]
	always_ff @(posedge clk)
	begin
		if (srst)
			proc_mode_status_reg <= MODE_STAT_RST; // [RL6]
		else if (rst_seen_reg)
			proc_mode_status_reg[PM_MODE] <= pin_sync_reg; // [RL8] [RL9]
		else if (s_bvalid && awaddr_reg == REG_MODE_STAT && wstrb_reg[0])
			proc_mode_status_reg <= wdata_reg[3:0]; // [RL10] [RL11]
	end

	// Global allocation register
	always_ff @(posedge clk)
	begin
		if (srst)
			global_alloc_reg <= 8'h00;
		else if (s_bvalid && awaddr_reg == REG_GALLOC && wstrb_reg[0])
			global_alloc_reg <= wdata_reg[7:0]; // [RL2]
	end

	// AXI read channel, one-cycle registered answer
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h00000000;
			s_rresp <= RESP_OKAY;
		end
		else if (s_rvalid)
		begin
			if (s_rready)
				s_rvalid <= 1'b0;
		end
		else if (s_arvalid)
		begin
			s_rvalid <= 1'b1;
			s_rresp <= RESP_OKAY;
			case (s_araddr)
				REG_MODE_STAT: s_rdata <= {28'h0000000, proc_mode_status_reg}; // [RL10]
				REG_GALLOC: s_rdata <= {24'h000000, global_alloc_reg};
				REG_STAT: s_rdata <= {27'h0000000, global_bus_grant, tgt_q_reg};
				default:
				begin
					s_rdata <= 32'h00000000;
					s_rresp <= RESP_SLVERR;
				end
			endcase
		end
	end
	assign s_arready = !s_rvalid;
endmodule // mmd_decoder
`default_nettype wire

// ===== mmd_ext_model.sv
// Purpose: External memory and global bus arbiter model
// Assumes: Read data is the address XOR 5A5Ah
// Notes: Slow mode adds two wait states; idle data toggles
`timescale 1ns/100ps
`default_nettype none
module mmd_ext_model (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Wait-state select
	input wire logic slow,
	// Bus from the decoder
	input wire mmd_pkg::mmd_ext_t ext_req,
	input wire logic global_bus_request,
	output logic [15:0] ext_rdata,
	output logic ext_ready,
	output logic global_bus_grant
);
	import mmd_pkg::*;
	logic [1:0] wait_reg;
	logic [1:0] gcnt_reg;
	logic [15:0] idle_reg;
	// Wait states counted while an access is offered
	always_ff @(posedge clk)
		if (srst || !ext_req.valid || ext_ready)
			wait_reg <= 2'h0;
		else if (wait_reg != 2'h3)
			wait_reg <= wait_reg + 2'h1;
	// Grant comes two cycles after the request
	always_ff @(posedge clk)
		if (srst || !global_bus_request)
			gcnt_reg <= 2'h0;
		else if (gcnt_reg != 2'h2)
			gcnt_reg <= gcnt_reg + 2'h1;
	assign global_bus_grant = gcnt_reg == 2'h2;
	// Answer once waits and any grant allow
	assign ext_ready = ext_req.valid && (!slow || wait_reg >= 2'h2)
		&& (!ext_req.global_sel || global_bus_grant);
	// Released data lines show the inverse of the last value
	always_ff @(posedge clk)
		idle_reg <= srst ? 16'h0000 : ~ext_rdata;
	assign ext_rdata = ext_ready ? ext_req.addr ^ 16'h5A5A : idle_reg;
endmodule // mmd_ext_model
`default_nettype wire

// ===== mmd_decoder_chk.sv
// Purpose: Port checks on the memory map decoder
// Assumes: One clock, synchronous reset
// Notes: Bound to every decoder instance
`timescale 1ns/100ps
`default_nettype none
module mmd_decoder_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Core side
	input wire mmd_pkg::mmd_req_t core_req,
	input wire logic core_ready,
	input wire logic [15:0] core_rdata,
	input wire mmd_pkg::mmd_tgt_t core_tgt,
	// External side
	input wire mmd_pkg::mmd_ext_t ext_req,
	input wire logic [15:0] ext_rdata,
	input wire logic ext_ready,
	input wire logic global_bus_request,
	input wire logic global_bus_grant,
	input wire logic mmr_sel
);
	import mmd_pkg::*;
	logic dv;
	// Data-space access offered
	assign dv = core_req.valid && core_req.space == SP_DATA;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_mmr;
		dv && core_req.addr <= MMR_LIMIT |-> mmr_sel && core_ready && core_tgt == MMD_TGT_MMR;
	endproperty
	a_mmr: assert property (p_mmr) else $error("register area decode wrong");
	property p_b2;
		dv && core_req.addr inside {[BLK2_BASE:BLK2_LIMIT]} |-> core_tgt == MMD_TGT_BLK2;
	endproperty
	a_b2: assert property (p_b2) else $error("block two decode wrong");
	property p_b1;
		dv && core_req.addr inside {[BLK1_BASE:BLK1_LIMIT]} |-> core_tgt == MMD_TGT_BLK1;
	endproperty
	a_b1: assert property (p_b1) else $error("block one decode wrong");
	property p_io;
		core_req.valid && core_req.space == SP_IO |-> core_tgt == MMD_TGT_EXT
			&& ext_req.valid && ext_req.addr == core_req.addr;
	endproperty
	a_io: assert property (p_io) else $error("io access not external");
	property p_lat;
		$rose(core_req.valid) && core_tgt == MMD_TGT_BLK1 |-> !core_ready ##1 core_ready;
	endproperty
	a_lat: assert property (p_lat) else $error("on-chip latency wrong");
	property p_wait;
		global_bus_request && !global_bus_grant |-> !core_ready;
	endproperty
	a_wait: assert property (p_wait) else $error("global access before grant");
	property p_gsel;
		core_req.valid && core_tgt == MMD_TGT_GLOBAL |-> global_bus_request && ext_req.global_sel;
	endproperty
	a_gsel: assert property (p_gsel) else $error("global region not requested");
	property p_ext;
		core_req.valid && core_tgt == MMD_TGT_EXT |-> core_ready == ext_ready
			&& (!ext_ready || core_req.wr || core_rdata == ext_rdata);
	endproperty
	a_ext: assert property (p_ext) else $error("external answer wrong");
	c_glob: cover property (core_ready && core_tgt == MMD_TGT_GLOBAL);
	c_blk0: cover property (core_ready && core_tgt == MMD_TGT_BLK0);
	c_flash: cover property (core_ready && core_tgt == MMD_TGT_FLASH);
endmodule // mmd_decoder_chk
bind mmd_decoder mmd_decoder_chk u_chk (.*);
`default_nettype wire

// ===== test_mmd_decoder.sv
// Purpose: Self-checking bench for the memory map decoder
// Assumes: External model returns address XOR 5A5Ah
// Notes: Each scenario task drives and judges its accesses
`timescale 1ns/100ps
`default_nettype none
module test_mmd_decoder;
	import mmd_pkg::*;
	logic clk = 0, srst = 1, pin = 1, slow = 0, erdy, ggr, gbr, mmr, rdy;
	logic awr, wrd, bv, arr, rv, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [7:0] aw = 0, ar = 0;
	logic [31:0] wd = 0, rdat, ard;
	logic [1:0] bresp, rr, aresp;
	logic [15:0] rd, erd, got;
	mmd_req_t req = '0;
	mmd_ext_t ext;
	mmd_tgt_t tgt, gtgt;
	int num_errors = 0, n_compared = 0;
	always #50 clk = ~clk;
	// Decoder and external model
	mmd_decoder DUT (.clk(clk), .srst(srst), .proc_mode_pin(pin), .core_req(req),
		.core_ready(rdy), .core_rdata(rd), .core_tgt(tgt), .ext_req(ext), .ext_rdata(erd),
		.ext_ready(erdy), .global_bus_request(gbr), .global_bus_grant(ggr), .mmr_sel(mmr),
		.s_awaddr(aw), .s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hF),
		.s_wvalid(wv), .s_wready(wrd), .s_bresp(bresp), .s_bvalid(bv), .s_bready(bry),
		.s_araddr(ar), .s_arvalid(arv), .s_arready(arr), .s_rdata(rdat), .s_rresp(rr),
		.s_rvalid(rv), .s_rready(rry));
	mmd_ext_model u_ext (.clk(clk), .srst(srst), .slow(slow), .ext_req(ext),
		.global_bus_request(gbr), .ext_rdata(erd), .ext_ready(erdy), .global_bus_grant(ggr));
	task report_and_stop;
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			$display("[ERR] %0t got %h exp %h", $time, g, e);
			num_errors++;
		end
	endtask
	task hang;
		num_errors++;
		report_and_stop;
	endtask
	// One core access, held until ready
	task core(input logic [1:0] sp, input logic w, input logic [15:0] a, input logic [15:0] d);
		int i;
		@(posedge clk);
		req <= '{1'b1, w, sp, a, d};
		for (i = 0; i < 20; i++)
		begin
			@(negedge clk);
			if (rdy === 1'b1)
				break;
		end
		if (i == 20)
			hang;
		got = rd;
		gtgt = tgt;
		@(posedge clk);
		req.valid <= 1'b0;
	endtask
	// Register write over AXI4-Lite
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wrd)
				wv <= 1'b0;
			if (bv)
				break;
		end
		if (i == 20)
			hang;
		bry <= 1'b0;
		chk(bresp, RESP_OKAY);
	endtask
	// Register read over AXI4-Lite
	task axi_rd(input logic [7:0] a);
		int i;
		@(posedge clk);
		ar <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv)
				break;
		end
		if (i == 20)
			hang;
		ard = rdat;
		aresp = rr;
		rry <= 1'b0;
	endtask
	// Status after reset with pin high, unmapped read, external boot fetch
	task t_boot;
		axi_rd(REG_MODE_STAT);
		chk(ard, 32'h0000000D);
		axi_rd(REG_GALLOC);
		chk(ard, 32'h00000000);
		axi_rd(8'h0C);
		chk(aresp, RESP_SLVERR);
		core(SP_PROG, 1'b0, 16'h0000, 16'h0000);
		chk(gtgt, MMD_TGT_EXT);
		chk(got, 16'h5A5A);
	endtask
	// Clearing mode bit maps flash at zero
	task t_flash;
		axi_wr(REG_MODE_STAT, 32'h0000000C);
		axi_rd(REG_MODE_STAT);
		chk(ard, 32'h0000000C);
		core(SP_PROG, 1'b1, 16'h7FFF, 16'h1234);
		core(SP_PROG, 1'b0, 16'h7FFF, 16'h0000);
		chk(got, 16'h1234);
		chk(gtgt, MMD_TGT_FLASH);
		core(SP_PROG, 1'b0, 16'h0000, 16'h0000);
		chk(gtgt, MMD_TGT_FLASH);
	endtask
	// Block zero aliases in data, then in program space
	task t_blk0;
		core(SP_DATA, 1'b1, 16'h0105, 16'hBEEF);
		core(SP_DATA, 1'b0, 16'h0205, 16'h0000);
		chk(got, 16'hBEEF);
		axi_wr(REG_MODE_STAT, 32'h0000000E);
		core(SP_PROG, 1'b1, 16'hFE07, 16'h0F0F);
		core(SP_PROG, 1'b0, 16'hFF07, 16'h0000);
		chk(got, 16'h0F0F);
		chk(gtgt, MMD_TGT_BLK0);
		axi_wr(REG_MODE_STAT, 32'h0000000C);
	endtask
	// Block one alias, block two, register area, separate I/O space
	task t_misc;
		core(SP_DATA, 1'b1, 16'h0310, 16'hA1A1);
		core(SP_DATA, 1'b0, 16'h0410, 16'h0000);
		chk(got, 16'hA1A1);
		core(SP_DATA, 1'b1, 16'h007F, 16'h00B2);
		core(SP_DATA, 1'b0, 16'h007F, 16'h0000);
		chk(got, 16'h00B2);
		core(SP_DATA, 1'b0, 16'h005F, 16'h0000);
		chk(gtgt, MMD_TGT_MMR);
		core(SP_IO, 1'b0, 16'h0310, 16'h0000);
		chk(got, 16'h594A);
	endtask
	// Shared single RAM and its two enables
	task t_single_access_ram;
		core(SP_DATA, 1'b1, 16'h0805, 16'h5555);
		core(SP_PROG, 1'b0, 16'h8005, 16'h0000);
		chk(got, 16'h5555);
		axi_wr(REG_MODE_STAT, 32'h00000004);
		core(SP_DATA, 1'b0, 16'h0805, 16'h0000);
		chk(gtgt, MMD_TGT_EXT);
		chk(got, 16'h525F);
		axi_wr(REG_MODE_STAT, 32'h00000000);
		core(SP_PROG, 1'b0, 16'h8005, 16'h0000);
		chk(gtgt, MMD_TGT_EXT);
	endtask
	// Global region sizes with a slow external bus
	task t_global;
		slow <= 1'b1;
		axi_wr(REG_GALLOC, 32'h000000FF);
		core(SP_DATA, 1'b0, 16'hFF10, 16'h0000);
		chk(gtgt, MMD_TGT_GLOBAL);
		chk(got, 16'hA54A);
		core(SP_DATA, 1'b0, 16'hFE10, 16'h0000);
		chk(gtgt, MMD_TGT_EXT);
		axi_wr(REG_GALLOC, 32'h00000080);
		core(SP_DATA, 1'b0, 16'h8000, 16'h0000);
		chk(gtgt, MMD_TGT_GLOBAL);
		core(SP_DATA, 1'b0, 16'h7FFF, 16'h0000);
		chk(gtgt, MMD_TGT_EXT);
	endtask
	// Second reset with the pin low latches microcontroller mode
	task t_reset2;
		pin <= 1'b0;
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		axi_rd(REG_MODE_STAT);
		chk(ard, 32'h0000000C);
		core(SP_PROG, 1'b0, 16'h0000, 16'h0000);
		chk(gtgt, MMD_TGT_FLASH);
	endtask
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_boot;
		t_flash;
		t_blk0;
		t_misc;
		t_single_access_ram;
		t_global;
		t_reset2;
		report_and_stop;
	end
endmodule // test_mmd_decoder
`default_nettype wire
